// File: verilog/cpu_instr_exec_subset.sv
// Execution unit for rotate, return, subtract, bit, carry, stack copy, swap, trap and test
`timescale 1ns/1ps
`default_nettype none
`include "cpu_exec_defs.svh"
module cpu_instr_exec_subset (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] dest_in,
  input wire logic [7:0] src_in,
  input wire logic [15:0] next_pc,
  input wire logic load,
  input wire logic [7:0] load_a,
  input wire logic [7:0] load_b,
  input wire logic [7:0] load_sp,
  input wire logic [7:0] load_st,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic unsupported,
  output logic [7:0] reg_a,
  output logic [7:0] reg_b,
  output logic [7:0] stack_pointer,
  output logic [7:0] flag_byte,
  output logic [15:0] pc,
  output logic rd_wr,
  output logic [7:0] rd_data,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata
);

  // ***************************************************************
  // Decode
  // ***************************************************************
  function automatic logic is_arith(input logic [7:0] op);
    is_arith = (op[3:0] == `NIB_SUB || op[3:0] == `NIB_SBB) && op[7:4] >= `HI_RS_A && op[7:4] <= `HI_IMM_RD;
  endfunction

  function automatic cpu_exec_pkg::op_class_t op_class(input logic [7:0] op);
    op_class = cpu_exec_pkg::CLS_NONE;
    if (is_arith(op)) begin
      op_class = (op[3:0] == `NIB_SBB) ? cpu_exec_pkg::CLS_SBB : cpu_exec_pkg::CLS_SUB;
    end else if (op >= `OP_TRAP15 && op <= `OP_TRAP0) begin
      op_class = cpu_exec_pkg::CLS_TRAP;
    end else begin
      unique case (op)
        `OP_RRC_A, `OP_RRC_B, `OP_RRC_R: op_class = cpu_exec_pkg::CLS_RRC;
        `OP_CLR_R, `OP_CLR_P: op_class = cpu_exec_pkg::CLS_AND;
        `OP_SET_R, `OP_SET_P: op_class = cpu_exec_pkg::CLS_OR;
        `OP_SWAP_A, `OP_SWAP_B, `OP_SWAP_R: op_class = cpu_exec_pkg::CLS_SWAP;
        `OP_TST_A, `OP_TST_B: op_class = cpu_exec_pkg::CLS_TST;
        `OP_CARRY_FORCE: op_class = cpu_exec_pkg::CLS_CARRY_FORCE;
        `OP_STACK_POINTER_COPY: op_class = cpu_exec_pkg::CLS_STACK_POINTER_COPY;
        `OP_RTI: op_class = cpu_exec_pkg::CLS_RTI;
        `OP_RTS: op_class = cpu_exec_pkg::CLS_RTS;
        default: op_class = cpu_exec_pkg::CLS_NONE;
      endcase
    end
  endfunction

  function automatic cpu_exec_pkg::dest_sel_t op_dest(input logic [7:0] op);
    op_dest = cpu_exec_pkg::DST_RD;
    if (is_arith(op)) begin
      if (op[7:4] == `HI_RS_A || op[7:4] == `HI_IMM_A || op[7:4] == `HI_B_A) begin
        op_dest = cpu_exec_pkg::DST_A;
      end else if (op[7:4] == `HI_RS_B || op[7:4] == `HI_IMM_B) begin
        op_dest = cpu_exec_pkg::DST_B;
      end
    end else if (op == `OP_RRC_A || op == `OP_SWAP_A || op == `OP_TST_A) begin
      op_dest = cpu_exec_pkg::DST_A;
    end else if (op == `OP_RRC_B || op == `OP_SWAP_B || op == `OP_TST_B) begin
      op_dest = cpu_exec_pkg::DST_B;
    end
  endfunction

  function automatic logic [3:0] op_cycles(input logic [7:0] op);
    op_cycles = `CYC_NONE;
    if (is_arith(op)) begin
      unique case (op[7:4])
        `HI_RS_A, `HI_RS_B: op_cycles = `CYC_SUB_RS_AB;
        `HI_IMM_A, `HI_IMM_B: op_cycles = `CYC_SUB_IMM_AB;
        `HI_RS_RD: op_cycles = `CYC_SUB_RS_RD;
        `HI_B_A: op_cycles = `CYC_SUB_B_A;
        default: op_cycles = `CYC_SUB_IMM_RD;
      endcase
    end else if (op >= `OP_TRAP15 && op <= `OP_TRAP0) begin
      op_cycles = `CYC_TRAP;
    end else begin
      unique case (op)
        `OP_RRC_A, `OP_RRC_B: op_cycles = `CYC_RRC_AB;
        `OP_RRC_R: op_cycles = `CYC_RRC_R;
        `OP_CLR_R, `OP_SET_R: op_cycles = `CYC_BIT_R;
        `OP_CLR_P, `OP_SET_P: op_cycles = `CYC_BIT_P;
        `OP_SWAP_A, `OP_SWAP_B: op_cycles = `CYC_SWAP_AB;
        `OP_SWAP_R: op_cycles = `CYC_SWAP_R;
        `OP_TST_A: op_cycles = `CYC_TST_A;
        `OP_TST_B: op_cycles = `CYC_TST_B;
        `OP_CARRY_FORCE: op_cycles = `CYC_CARRY_FORCE;
        `OP_STACK_POINTER_COPY: op_cycles = `CYC_STACK_POINTER_COPY;
        `OP_RTI: op_cycles = `CYC_RTI;
        `OP_RTS: op_cycles = `CYC_RTS;
        default: op_cycles = `CYC_NONE;
      endcase
    end
  endfunction

  // ***************************************************************
  // State
  // ***************************************************************
  cpu_exec_pkg::exec_state_t state_reg, state_next;
  cpu_exec_pkg::capture_t cap_reg, cap_next;
  logic [7:0] op_reg, op_next, dst_reg, dst_next, src_reg, src_next;
  logic [3:0] cyc_reg, cyc_next, step_reg, step_next;
  logic [7:0] a_reg, a_next, b_reg, b_next, sp_reg, sp_next, st_reg, st_next;
  logic [15:0] pc_reg, pc_next, mem_addr_reg, mem_addr_next;
  logic done_reg, done_next, unsup_reg, unsup_next, rd_wr_reg, rd_wr_next;
  logic mem_rd_reg, mem_rd_next, mem_wr_reg, mem_wr_next;
  logic [7:0] rd_data_reg, rd_data_next, mem_wdata_reg, mem_wdata_next;

  cpu_exec_pkg::op_class_t cls;
  cpu_exec_pkg::dest_sel_t dsel;
  logic [7:0] alu_dst, alu_src, alu_res, sp_inc;
  logic alu_c, alu_n, alu_z, alu_v, last_step;
  logic [3:0] trap_n;
  logic [15:0] vec_hi_addr;

  assign cls = op_class(op_reg);
  assign dsel = op_dest(op_reg);
  assign alu_dst = (dsel == cpu_exec_pkg::DST_A) ? a_reg : (dsel == cpu_exec_pkg::DST_B) ? b_reg : dst_reg;
  assign alu_src = (is_arith(op_reg) && op_reg[7:4] == `HI_B_A) ? b_reg : src_reg;
  assign last_step = (step_reg == cyc_reg - 4'd1);
  assign sp_inc = sp_reg + 8'h01;
  assign trap_n = 4'(`OP_TRAP0 - op_reg);
  assign vec_hi_addr = `VEC_TOP - {11'h000, trap_n, 1'b0};

  exec_alu alu (
    .cls(cls),
    .dst(alu_dst),
    .src(alu_src),
    .cin(st_reg[`FLG_C]),
    .res(alu_res),
    .c_out(alu_c),
    .n_out(alu_n),
    .z_out(alu_z),
    .v_out(alu_v)
  );

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  always_comb begin
    state_next = state_reg;
    cap_next = cap_reg;
    op_next = op_reg;
    dst_next = dst_reg;
    src_next = src_reg;
    cyc_next = cyc_reg;
    step_next = step_reg;
    a_next = a_reg;
    b_next = b_reg;
    sp_next = sp_reg;
    st_next = st_reg;
    pc_next = pc_reg;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    rd_data_next = rd_data_reg;
    done_next = 1'b0;
    unsup_next = 1'b0;
    rd_wr_next = 1'b0;
    mem_rd_next = 1'b0;
    mem_wr_next = 1'b0;
    // Read data is valid in the cycle the strobe stands
    if (mem_rd_reg) begin
      unique case (cap_reg)
        cpu_exec_pkg::CAP_PC_LO: pc_next[7:0] = mem_rdata;
        cpu_exec_pkg::CAP_PC_HI: pc_next[15:8] = mem_rdata;
        cpu_exec_pkg::CAP_ST: st_next = mem_rdata;
      endcase
    end
    unique case (state_reg)
      cpu_exec_pkg::S_IDLE: begin
        if (load) begin
          a_next = load_a;
          b_next = load_b;
          sp_next = load_sp;
          st_next = load_st;
        end
        if (start) begin
          op_next = opcode;
          dst_next = dest_in;
          src_next = src_in;
          pc_next = next_pc;
          cyc_next = op_cycles(opcode);
          step_next = 4'd0;
          state_next = cpu_exec_pkg::S_RUN;
        end
      end
      cpu_exec_pkg::S_RUN: begin
        step_next = step_reg + 4'd1;
        if ((cls == cpu_exec_pkg::CLS_RTS || cls == cpu_exec_pkg::CLS_RTI) &&
            (step_reg == 4'd1 || step_reg == 4'd2 || (cls == cpu_exec_pkg::CLS_RTI && step_reg == 4'd3))) begin
          mem_rd_next = 1'b1;
          mem_addr_next = {`STACK_PAGE, sp_reg};
          sp_next = sp_reg - 8'h01;
          cap_next = (step_reg == 4'd1) ? cpu_exec_pkg::CAP_PC_LO :
                     (step_reg == 4'd2) ? cpu_exec_pkg::CAP_PC_HI : cpu_exec_pkg::CAP_ST;
        end
        if (cls == cpu_exec_pkg::CLS_TRAP) begin
          if (step_reg == 4'd1 || step_reg == 4'd2) begin
            sp_next = sp_inc;
            mem_wr_next = 1'b1;
            mem_addr_next = {`STACK_PAGE, sp_inc};
            mem_wdata_next = (step_reg == 4'd1) ? pc_reg[15:8] : pc_reg[7:0];
          end else if (step_reg == 4'd3) begin
            mem_rd_next = 1'b1;
            mem_addr_next = vec_hi_addr;
            cap_next = cpu_exec_pkg::CAP_PC_HI;
          end else if (step_reg == 4'd4) begin
            mem_rd_next = 1'b1;
            mem_addr_next = vec_hi_addr + 16'h0001;
            cap_next = cpu_exec_pkg::CAP_PC_LO;
          end
        end
        if (last_step) begin
          done_next = 1'b1;
          state_next = cpu_exec_pkg::S_IDLE;
          unique case (cls)
            cpu_exec_pkg::CLS_RRC, cpu_exec_pkg::CLS_SBB, cpu_exec_pkg::CLS_SUB, cpu_exec_pkg::CLS_AND,
            cpu_exec_pkg::CLS_OR, cpu_exec_pkg::CLS_SWAP, cpu_exec_pkg::CLS_TST: begin
              st_next[`FLG_C] = alu_c;
              st_next[`FLG_N] = alu_n;
              st_next[`FLG_Z] = alu_z;
              st_next[`FLG_V] = alu_v;
              if (cls != cpu_exec_pkg::CLS_TST) begin
                unique case (dsel)
                  cpu_exec_pkg::DST_A: a_next = alu_res;
                  cpu_exec_pkg::DST_B: b_next = alu_res;
                  cpu_exec_pkg::DST_RD: begin
                    rd_wr_next = 1'b1;
                    rd_data_next = alu_res;
                  end
                endcase
              end
            end
            cpu_exec_pkg::CLS_CARRY_FORCE: begin
              st_next[`FLG_C] = 1'b1;
              st_next[`FLG_N] = 1'b0;
              st_next[`FLG_Z] = 1'b1;
              st_next[`FLG_V] = 1'b0;
            end
            cpu_exec_pkg::CLS_STACK_POINTER_COPY: b_next = sp_reg;
            cpu_exec_pkg::CLS_NONE: unsup_next = 1'b1;
            default: begin
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= cpu_exec_pkg::S_IDLE;
      cap_reg <= cpu_exec_pkg::CAP_PC_LO;
      op_reg <= 8'h00;
      dst_reg <= 8'h00;
      src_reg <= 8'h00;
      cyc_reg <= `CYC_NONE;
      step_reg <= 4'd0;
      a_reg <= `RST_A;
      b_reg <= `RST_B;
      sp_reg <= `RST_SP;
      st_reg <= `RST_ST;
      pc_reg <= `RST_PC;
      mem_addr_reg <= 16'h0000;
      mem_wdata_reg <= 8'h00;
      rd_data_reg <= 8'h00;
      done_reg <= 1'b0;
      unsup_reg <= 1'b0;
      rd_wr_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cap_reg <= cap_next;
      op_reg <= op_next;
      dst_reg <= dst_next;
      src_reg <= src_next;
      cyc_reg <= cyc_next;
      step_reg <= step_next;
      a_reg <= a_next;
      b_reg <= b_next;
      sp_reg <= sp_next;
      st_reg <= st_next;
      pc_reg <= pc_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      rd_data_reg <= rd_data_next;
      done_reg <= done_next;
      unsup_reg <= unsup_next;
      rd_wr_reg <= rd_wr_next;
      mem_rd_reg <= mem_rd_next;
      mem_wr_reg <= mem_wr_next;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign busy = (state_reg == cpu_exec_pkg::S_RUN);
  assign done = done_reg;
  assign unsupported = unsup_reg;
  assign reg_a = a_reg;
  assign reg_b = b_reg;
  assign stack_pointer = sp_reg;
  assign flag_byte = st_reg;
  assign pc = pc_reg;
  assign rd_wr = rd_wr_reg;
  assign rd_data = rd_data_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_rd = mem_rd_reg;
  assign mem_wr = mem_wr_reg;
  assign mem_wdata = mem_wdata_reg;
endmodule
`default_nettype wire

// File: pkg/cpu_exec_defs.svh
// Opcodes, cycle counts, flag positions and reset values of the execution subset
`ifndef CPU_EXEC_DEFS_SVH
`define CPU_EXEC_DEFS_SVH

// ***************************************************************
// Opcodes
// ***************************************************************
`define OP_RTI 8'hfa
`define OP_RTS 8'hf9
`define OP_CARRY_FORCE 8'hf8
`define OP_STACK_POINTER_COPY 8'hfe
`define OP_TRAP0 8'hef
`define OP_TRAP15 8'he0
`define OP_CLR_R 8'h73
`define OP_CLR_P 8'ha3
`define OP_SET_R 8'h74
`define OP_SET_P 8'ha4
`define OP_TST_A 8'hb0
`define OP_TST_B 8'hc6
`define OP_SWAP_A 8'hb7
`define OP_SWAP_B 8'hc7
`define OP_SWAP_R 8'hd7
`define OP_RRC_A 8'hbd
`define OP_RRC_B 8'hcd
`define OP_RRC_R 8'hdd
`define NIB_SUB 4'ha
`define NIB_SBB 4'hb
`define HI_RS_A 4'h1
`define HI_IMM_A 4'h2
`define HI_RS_B 4'h3
`define HI_RS_RD 4'h4
`define HI_IMM_B 4'h5
`define HI_B_A 4'h6
`define HI_IMM_RD 4'h7

// ***************************************************************
// Cycle counts
// ***************************************************************
`define CYC_RTI 4'd12
`define CYC_RTS 4'd9
`define CYC_CARRY_FORCE 4'd7
`define CYC_STACK_POINTER_COPY 4'd8
`define CYC_TRAP 4'd14
`define CYC_BIT_R 4'd8
`define CYC_BIT_P 4'd10
`define CYC_TST_A 4'd9
`define CYC_TST_B 4'd10
`define CYC_SWAP_AB 4'd11
`define CYC_SWAP_R 4'd9
`define CYC_RRC_AB 4'd8
`define CYC_RRC_R 4'd6
`define CYC_SUB_RS_AB 4'd7
`define CYC_SUB_IMM_AB 4'd6
`define CYC_SUB_RS_RD 4'd9
`define CYC_SUB_B_A 4'd8
`define CYC_SUB_IMM_RD 4'd8
`define CYC_NONE 4'd1

// ***************************************************************
// Flag byte layout, vectors, reset values
// ***************************************************************
`define FLG_C 7
`define FLG_N 6
`define FLG_Z 5
`define FLG_V 4
`define VEC_TOP 16'h7fde
`define STACK_PAGE 8'h00
`define RST_A 8'h00
`define RST_B 8'h00
`define RST_SP 8'h00
`define RST_ST 8'h00
`define RST_PC 16'h0000

`endif

// File: pkg/cpu_exec_pkg.sv
// Types shared by the execution subset
package cpu_exec_pkg;
  typedef enum logic [3:0] {
    CLS_NONE, CLS_RRC, CLS_SBB, CLS_SUB, CLS_AND, CLS_OR, CLS_CARRY_FORCE,
    CLS_STACK_POINTER_COPY, CLS_SWAP, CLS_TST, CLS_RTI, CLS_RTS, CLS_TRAP
  } op_class_t;
  typedef enum logic [1:0] {DST_A, DST_B, DST_RD} dest_sel_t;
  typedef enum logic [1:0] {CAP_PC_LO, CAP_PC_HI, CAP_ST} capture_t;
  typedef enum logic {S_IDLE, S_RUN} exec_state_t;
endpackage

// File: verilog/exec_alu.sv
// Combinational result and flag unit for the execution subset
`timescale 1ns/1ps
`default_nettype none
module exec_alu (
  input wire cpu_exec_pkg::op_class_t cls,
  input wire logic [7:0] dst,
  input wire logic [7:0] src,
  input wire logic cin,
  output logic [7:0] res,
  output logic c_out,
  output logic n_out,
  output logic z_out,
  output logic v_out
);
  logic [8:0] diff;

  always_comb begin
    diff = 9'h000;
    res = dst;
    c_out = cin;
    unique case (cls)
      cpu_exec_pkg::CLS_RRC: begin
        res = {cin, dst[7:1]};
        c_out = dst[0];
      end
      cpu_exec_pkg::CLS_SUB: begin
        diff = {1'b0, dst} - {1'b0, src};
        res = diff[7:0];
        c_out = ~diff[8];
      end
      cpu_exec_pkg::CLS_SBB: begin
        diff = {1'b0, dst} - {1'b0, src} - {8'h00, ~cin};
        res = diff[7:0];
        c_out = ~diff[8];
      end
      cpu_exec_pkg::CLS_AND: begin
        res = dst & src;
        c_out = 1'b0;
      end
      cpu_exec_pkg::CLS_OR: begin
        res = dst | src;
        c_out = 1'b0;
      end
      cpu_exec_pkg::CLS_SWAP: begin
        res = {dst[3:0], dst[7:4]};
        c_out = dst[4];
      end
      cpu_exec_pkg::CLS_TST: begin
        res = dst;
        c_out = 1'b0;
      end
      default: begin
        res = dst;
        c_out = cin;
      end
    endcase
    n_out = res[7];
    z_out = (res == 8'h00);
    if (cls == cpu_exec_pkg::CLS_SUB || cls == cpu_exec_pkg::CLS_SBB) begin
      v_out = (c_out ^ n_out) & (src[7] ^ dst[7]);
    end else begin
      v_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: test/exec_mem_model.sv
// Behavioural program and data memory on the far side of the execution unit
`timescale 1ns/1ps
`default_nettype none
module exec_mem_model (
  input wire logic core_clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg = 8'h00;
  // Undriven read data shows the inverse of the last byte, never a stale copy
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_reg;
  always @(posedge core_clk) begin
    if (mem_rd) last_reg <= mem[mem_addr];
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
endmodule
`default_nettype wire

// File: test/cpu_instr_exec_subset_sva.sv
// Port-level assertions for the execution subset unit
`timescale 1ns/1ps
`default_nettype none
`include "cpu_exec_defs.svh"
module cpu_instr_exec_subset_sva (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic load,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] opcode,
  input wire logic [7:0] src_in,
  input wire logic [15:0] next_pc,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] reg_a,
  input wire logic [7:0] stack_pointer,
  input wire logic [7:0] flag_byte,
  input wire logic [15:0] pc,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata
);
  // ***************************************************************
  // Accepted start
  // ***************************************************************
  logic tk;
  assign tk = start && !busy && !load;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_rrc_a_result: assert property (tk && opcode == `OP_RRC_A |-> ##9 done &&
    reg_a == {$past(flag_byte[`FLG_C], 7), $past(reg_a[7:1], 7)} && flag_byte[`FLG_C] == $past(reg_a[0], 7))
    else $error("rotate result wrong");
  a_rti_span_flags: assert property (tk && opcode == `OP_RTI |=> (busy && !done)[*8] ##5
    done && flag_byte == $past(mem_rdata, 8))
    else $error("interrupt return timing or flags wrong");
  a_rts_pop_order: assert property (tk && opcode == `OP_RTS |-> ##3 mem_rd &&
    mem_addr == {8'h00, $past(stack_pointer)} ##1 mem_rd && mem_addr == {8'h00, $past(stack_pointer, 2) - 8'h01})
    else $error("return pop order wrong");
  a_rts_flags_kept: assert property (tk && opcode == `OP_RTS |=> $stable(flag_byte)[*8] ##2 done)
    else $error("return changed flags");
  a_carry_force_flag_values: assert property (tk && opcode == `OP_CARRY_FORCE |-> ##8 done &&
    flag_byte[7:4] == 4'ha && flag_byte[3:0] == $past(flag_byte[3:0], 6))
    else $error("carry force flags wrong");
  a_sub_carry_result: assert property (tk && opcode == 8'h2a |-> ##7 done &&
    reg_a == $past(reg_a, 5) - $past(src_in, 7) && flag_byte[`FLG_C] == ($past(reg_a, 5) >= $past(src_in, 7)))
    else $error("subtract result or carry wrong");
  a_trap_push_order: assert property (tk && opcode[7:4] == 4'he |-> ##3 mem_wr &&
    mem_addr == {8'h00, $past(stack_pointer) + 8'h01} && mem_wdata == $past(next_pc[15:8], 3) ##1 mem_wr &&
    mem_addr == {8'h00, $past(stack_pointer, 2) + 8'h02} && mem_wdata == $past(next_pc[7:0], 4))
    else $error("trap push wrong");
  a_trap_vector_load: assert property (tk && opcode[7:4] == 4'he |-> ##5 mem_rd &&
    mem_addr == `VEC_TOP - {11'h000, ~$past(opcode[3:0], 5), 1'b0} ##1 mem_rd &&
    mem_addr == `VEC_TOP - {11'h000, ~$past(opcode[3:0], 6), 1'b0} + 16'h0001 ##9 done &&
    pc == {$past(mem_rdata, 10), $past(mem_rdata, 9)})
    else $error("trap vector fetch wrong");
endmodule
bind cpu_instr_exec_subset cpu_instr_exec_subset_sva chk (.core_clk(core_clk), .rst_b(rst_b), .start(start),
  .load(load), .busy(busy), .done(done), .opcode(opcode), .src_in(src_in), .next_pc(next_pc),
  .mem_rdata(mem_rdata), .reg_a(reg_a), .stack_pointer(stack_pointer), .flag_byte(flag_byte), .pc(pc),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata));
`default_nettype wire

// File: test/cpu_instr_exec_subset_tb.sv
// Self-checking bench for the execution subset unit with a behavioural memory
`timescale 1ns/1ps
`default_nettype none
`include "cpu_exec_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module cpu_instr_exec_subset_tb;
  typedef struct {logic [7:0] a, b, f, sp, rd, t1, t2; logic wr; logic [15:0] pc; int t0, cy;} note_t;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic load = 1'b0;
  logic busy, done, unsupported, rd_wr, mem_rd, mem_wr;
  logic [7:0] opcode = 8'h00, dest_in = 8'h00, src_in = 8'h00, load_a = 8'h00, load_b = 8'h00;
  logic [7:0] load_sp = 8'h00, load_st = 8'h00, mem_rdata, reg_a, reg_b, stack_pointer, flag_byte, rd_data, mem_wdata;
  logic [15:0] next_pc = 16'h0000, pc, mem_addr;
  logic [7:0] ma, mb, msp, mf;
  logic [7:0] bm [0:65535];
  logic [7:0] ops [$] = '{8'hbd, 8'hcd, 8'hdd, 8'h73, 8'ha3, 8'h74, 8'ha4, 8'hf8, 8'hfe, 8'hb7, 8'hc7, 8'hd7,
    8'hb0, 8'hc6, 8'hf9, 8'hfa};
  note_t q [$];
  note_t m;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  cpu_instr_exec_subset uut (.core_clk(core_clk), .rst_b(rst_b), .start(start), .opcode(opcode),
    .dest_in(dest_in), .src_in(src_in), .next_pc(next_pc), .load(load), .load_a(load_a), .load_b(load_b),
    .load_sp(load_sp), .load_st(load_st), .mem_rdata(mem_rdata), .busy(busy), .done(done),
    .unsupported(unsupported), .reg_a(reg_a), .reg_b(reg_b), .stack_pointer(stack_pointer),
    .flag_byte(flag_byte), .pc(pc), .rd_wr(rd_wr), .rd_data(rd_data), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata));
  exec_mem_model mem_i (.core_clk(core_clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // ***************************************************************
  // Reference model, driver and result monitor
  // ***************************************************************
  function automatic logic [7:0] fl(input logic c, input logic [7:0] r, input logic v);
    return {c, r[7], r == 8'h00, v, mf[3:0]};
  endfunction
  // Poke tries a start and a load mid-instruction; both must be ignored
  task automatic go(input logic [7:0] op, input logic poke);
    note_t n;
    logic [7:0] d, s, r, x;
    logic [8:0] sum;
    logic [15:0] p, y;
    int dst;
    d = 8'($urandom);
    s = 8'($urandom);
    p = 16'($urandom);
    r = 8'h00;
    n.pc = p;
    dst = 3;
    x = d;
    if (op[7:4] >= 4'hb && op[7:4] <= 4'hd) begin
      dst = op[7:4] - 4'hb;
      x = dst == 0 ? ma : dst == 1 ? mb : d;
    end
    if (op[7:4] inside {[4'h1:4'h7]} && op[3:1] == 3'b101) begin
      dst = (op[7:4] inside {4'h1, 4'h2, 4'h6}) ? 0 : (op[7:4] inside {4'h3, 4'h5}) ? 1 : 2;
      x = dst == 0 ? ma : dst == 1 ? mb : d;
      if (op[7:4] == 4'h6) s = mb;
      sum = {1'b0, x} + {1'b0, ~s} + {8'h00, op[0] ? mf[7] : 1'b1};
      r = sum[7:0];
      mf = fl(sum[8], r, (sum[8] ^ r[7]) & (s[7] ^ x[7]));
      n.cy = op[7:4] == 4'h4 ? 9 : op[7:4] inside {4'h2, 4'h5} ? 6 : op[7:4] inside {4'h6, 4'h7} ? 8 : 7;
    end else case (op)
      8'hbd, 8'hcd, 8'hdd: begin
        r = {mf[7], x[7:1]};
        mf = fl(x[0], r, 1'b0);
        n.cy = dst == 2 ? 6 : 8;
      end
      8'h73, 8'ha3, 8'h74, 8'ha4: begin
        r = op[0] ? x & s : x | s;
        mf = fl(1'b0, r, 1'b0);
        n.cy = op[7] ? 10 : 8;
        dst = 2;
      end
      8'hb7, 8'hc7, 8'hd7: begin
        r = {x[3:0], x[7:4]};
        mf = fl(x[4], r, 1'b0);
        n.cy = dst == 2 ? 9 : 11;
      end
      8'hb0, 8'hc6: begin
        mf = fl(1'b0, x, 1'b0);
        n.cy = dst + 9;
        dst = 3;
      end
      8'hf8: begin
        mf[7:4] = 4'ha;
        n.cy = 7;
      end
      8'hfe: begin
        mb = msp;
        n.cy = 8;
      end
      8'hf9, 8'hfa: begin
        n.pc = {bm[{8'h00, msp - 8'h01}], bm[{8'h00, msp}]};
        if (!op[0]) mf = bm[{8'h00, msp - 8'h02}];
        msp = msp - (op[0] ? 8'h02 : 8'h03);
        n.cy = op[0] ? 9 : 12;
      end
      default: begin
        bm[{8'h00, msp + 8'h01}] = p[15:8];
        bm[{8'h00, msp + 8'h02}] = p[7:0];
        msp = msp + 8'h02;
        y = `VEC_TOP - {11'h000, ~op[3:0], 1'b0};
        n.pc = {bm[y], bm[y + 16'h0001]};
        n.cy = 14;
      end
    endcase
    if (dst == 0) ma = r;
    if (dst == 1) mb = r;
    n.a = ma;
    n.b = mb;
    n.f = mf;
    n.sp = msp;
    n.wr = dst == 2;
    n.rd = r;
    n.t1 = bm[{8'h00, msp}];
    n.t2 = bm[{8'h00, msp - 8'h01}];
    @(posedge core_clk);
    start <= 1'b1;
    opcode <= op;
    dest_in <= d;
    src_in <= s;
    next_pc <= p;
    @(posedge core_clk);
    n.t0 = cyc + 1;
    q.push_back(n);
    start <= 1'b0;
    if (poke) begin
      @(posedge core_clk);
      start <= 1'b1;
      load <= 1'b1;
      load_a <= 8'($urandom);
      @(posedge core_clk);
      start <= 1'b0;
      load <= 1'b0;
      repeat (n.cy - 3) @(posedge core_clk);
    end else begin
      repeat (n.cy - 1) @(posedge core_clk);
    end
  endtask
  always @(posedge core_clk) begin
    if (rst_b && done === 1'b1) begin
      if (q.size() == 0) `CHK("done count", 1, 0)
      else begin
        m = q.pop_front();
        `CHK("cycles", m.cy, cyc - m.t0)
        `CHK("reg_a", m.a, reg_a)
        `CHK("reg_b", m.b, reg_b)
        `CHK("flag_byte", m.f, flag_byte)
        `CHK("stack_pointer", m.sp, stack_pointer)
        `CHK("pc", m.pc, pc)
        `CHK("rd_wr", m.wr, rd_wr)
        `CHK("busy", 1'b0, busy)
        `CHK("unsupported", 1'b0, unsupported)
        if (m.wr) `CHK("rd_data", m.rd, rd_data)
        `CHK("stack top", m.t1, mem_i.mem[{8'h00, m.sp}])
        `CHK("stack next", m.t2, mem_i.mem[{8'h00, m.sp - 8'h01}])
      end
    end
  end
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #500000;
    failures++;
    close_out();
  end
  initial begin
    void'($urandom(75));
    for (int i = 0; i < 65536; i++) begin
      bm[i] = 8'($urandom);
      mem_i.mem[i] = bm[i];
    end
    for (int h = 1; h < 8; h++) begin
      ops.push_back({4'(h), 4'ha});
      ops.push_back({4'(h), 4'hb});
    end
    for (int t = 0; t < 16; t++) ops.push_back(`OP_TRAP0 - 8'(t));
    ma = 8'($urandom);
    mb = 8'($urandom);
    msp = 8'($urandom);
    mf = 8'($urandom);
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    load <= 1'b1;
    load_a <= ma;
    load_b <= mb;
    load_sp <= msp;
    load_st <= mf;
    @(posedge core_clk);
    load <= 1'b0;
    foreach (ops[i]) go(ops[i], 1'b0);
    repeat (150) go(ops[$urandom_range(ops.size() - 1)], 1'($urandom));
    repeat (20) @(posedge core_clk);
    `CHK("pending results", 0, q.size())
    close_out();
  end
endmodule
`default_nettype wire
